/* File: hw/ptem_top.sv */
// Tag control logic: carrier timing, array sequencing, encoding, modulation and register slave.
//
// Functional notes
// [R01] All timing counted from recovered carrier edges.
// [R02] Hold logic reset until supply is good.
// [R03] Damping transistor follows the modulation signal.
// [R04] Reserved bit reads zero; lock set after programming.
// [R05] Locked part refuses all further programming.
// [R06] Rate field selects carrier cycles per bit.
// [R07] Default and programming period is 128 cycles.
// [R08] Configuration timing ignored until lock is set.
// [R09] Encoding field selects NRZ, biphase or Manchester.
// [R10] Modulation field; ASK drives encoded bit directly.
// [R11] FSK high: five undamped, five damped cycles.
// [R12] FSK low: four undamped, four damped cycles.
// [R13] First PSK flips phase on data change.
// [R14] Second PSK flips phase on every one.
// [R15] Serial frame of 96 or 128 bits.
// [R16] Programming addresses bits one to 128 serially.
// [R17] Word bit twelve is MSB, bit one LSB.
// [R18] Unlocked part runs native 128, FSK, NRZ.
// [R19] Locked part transmits with configured protocol.
// [R20] Power-up then gap answers 128 FSK ones.
// [R21] After blank check, enter programming mode.
// [R22] Echo after pass; field removal sets lock.
// [R23] Read mode repeats the frame continuously.
`timescale 1ns/1ps
`default_nettype none

module ptem_top
    import ptem_pkg::*;
#(
    parameter logic [11:0] FACTORY_CONFIG = 12'h000
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        carrier_clock,
    input  wire logic        field_present,
    input  wire logic        supply_good,
    input  wire logic        program_data,
    output logic             damping_on,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import ptem_pkg::*;

    // The array and the configuration word model non-volatile cells, so only the
    // chip-level reset touches them; the field power-on reset leaves them alone.
    localparam ptem_regs_type REGS_RESET = '{
        car_sync: 3'h0, car_lvl: 1'b0, fld_sync: 3'h0, fld_lvl: 1'b0,
        pwr_sync: 3'h0, pwr_lvl: 1'b0, dat_sync: 3'h0, dat_lvl: 1'b0,
        state: ST_POR, seen_gap: 1'b0,
        cfg: {1'b0, 1'b0, FACTORY_CONFIG[9:0]},
        mem: ARRAY_BLANK, bit_idx: 7'h00, cyc_cnt: 8'h00, grp_cnt: 4'h0,
        dlev: 1'b0, enc: 1'b0, phase: 1'b0, ptog: 1'b0, damp: 1'b0,
        aw_got: 1'b0, awaddr: 8'h00, w_got: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0,
        bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY
    };

    ptem_regs_type r_reg;
    ptem_regs_type r_next;

    logic       car_rise;
    logic       locked;
    logic       sending;
    logic [7:0] period;
    logic [6:0] last_bit;
    logic [7:0] n_cyc;
    logic [6:0] n_idx;
    logic       bit_end;
    logic       n_data;
    logic       half2;
    logic       n_dlev;
    logic       n_enc;
    logic [1:0] enc_sel;
    logic [1:0] mod_sel;
    logic [3:0] grp_len;
    logic [3:0] n_grp;
    logic       fsk_out;
    logic       n_phase;
    logic       n_ptog;
    logic [11:0] cfg_view;

    ////////////////////////////////////////////////////////////////////////////////
    // Bit timing and modulation.
    always_comb begin
        r_next = r_reg;

        // Three-stage synchronisers; a level is accepted once stages two and three agree.
        r_next.car_sync = {r_reg.car_sync[1:0], carrier_clock};
        r_next.fld_sync = {r_reg.fld_sync[1:0], field_present};
        r_next.pwr_sync = {r_reg.pwr_sync[1:0], supply_good};
        r_next.dat_sync = {r_reg.dat_sync[1:0], program_data};
        if (r_reg.car_sync[1] == r_reg.car_sync[2]) begin
            r_next.car_lvl = r_reg.car_sync[2];
        end
        if (r_reg.fld_sync[1] == r_reg.fld_sync[2]) begin
            r_next.fld_lvl = r_reg.fld_sync[2];
        end
        if (r_reg.pwr_sync[1] == r_reg.pwr_sync[2]) begin
            r_next.pwr_lvl = r_reg.pwr_sync[2];
        end
        if (r_reg.dat_sync[1] == r_reg.dat_sync[2]) begin
            r_next.dat_lvl = r_reg.dat_sync[2];
        end
        car_rise = (r_reg.car_sync[1] == r_reg.car_sync[2]) && r_reg.car_sync[2] && !r_reg.car_lvl; // [R01]

        locked = r_reg.cfg[POS_LOCK];
        // Configured protocol only once locked; native timing otherwise.
        if (locked && r_reg.state == ST_READ) begin // [R08] [R19]
            unique case (r_reg.cfg[POS_RATE_LO +: 3]) // [R06]
                RATE_CODE_32: period = DIVIDE_32_RATE;
                RATE_CODE_40: period = DIVIDE_40_RATE;
                RATE_CODE_50: period = DIVIDE_50_RATE;
                default:      period = DIVIDE_128_DEFAULT_RATE;
            endcase
            enc_sel  = r_reg.cfg[POS_ENC_LO +: 2];
            mod_sel  = r_reg.cfg[POS_MOD_LO +: 2];
            last_bit = r_reg.cfg[POS_LEN] ? LAST_BIT_128 : LAST_BIT_96; // [R15]
        end else begin
            period   = DIVIDE_128_DEFAULT_RATE; // [R07] [R18]
            enc_sel  = ENC_NRZ_LEVEL;
            mod_sel  = MOD_FSK;
            last_bit = LAST_BIT_128;
        end

        bit_end = (r_reg.cyc_cnt == period - 8'h01);
        n_cyc   = bit_end ? 8'h00 : r_reg.cyc_cnt + 8'h01;
        if (!bit_end) begin
            n_idx = r_reg.bit_idx;
        end else if (r_reg.bit_idx == last_bit) begin
            n_idx = 7'h00; // [R23]
        end else begin
            n_idx = r_reg.bit_idx + 7'h01; // [R16]
        end

        n_data = (r_reg.state == ST_BLANK) ? 1'b1 : r_reg.mem[n_idx]; // [R20]
        half2  = (n_cyc >= {1'b0, period[7:1]});
        n_dlev = r_reg.dlev;
        if (n_cyc == 8'h00) begin
            n_dlev = ~n_dlev;
        end
        if (n_cyc == {1'b0, period[7:1]} && !n_data) begin
            n_dlev = ~n_dlev;
        end
        unique case (enc_sel) // [R09]
            ENC_NRZ_LEVEL:    n_enc = n_data;
            ENC_MANCHESTER:   n_enc = half2 ? ~n_data : n_data;
            ENC_DIFF_BIPHASE: n_enc = n_dlev;
            ENC_INV_MANCH:    n_enc = half2 ? n_data : ~n_data;
        endcase

        // Groups restart at each bit so a bit never begins mid-group.
        grp_len = n_enc ? FSK_GROUP_HIGH : FSK_GROUP_LOW; // [R11] [R12]
        if (n_cyc == 8'h00 || r_reg.grp_cnt >= grp_len - 4'h1) begin
            n_grp = 4'h0;
        end else begin
            n_grp = r_reg.grp_cnt + 4'h1;
        end
        fsk_out = (n_grp >= {1'b0, grp_len[3:1]}); // [R11] [R12]

        n_ptog  = ~r_reg.ptog;
        n_phase = r_reg.phase;
        if (mod_sel == MOD_PHASE_FLIP_ON_DATA_CHANGE && n_enc != r_reg.enc) begin
            n_phase = ~n_phase; // [R13]
        end
        if (mod_sel == MOD_PHASE_FLIP_ON_ONE && n_cyc == 8'h00 && n_enc) begin
            n_phase = ~n_phase; // [R14]
        end

        sending = (r_reg.state == ST_NATIVE) || (r_reg.state == ST_BLANK) ||
                  (r_reg.state == ST_ECHO) || (r_reg.state == ST_READ);

        if (car_rise) begin
            r_next.cyc_cnt = n_cyc;
            r_next.bit_idx = n_idx;
            r_next.grp_cnt = n_grp;
            r_next.dlev    = n_dlev;
            r_next.enc     = n_enc;
            r_next.phase   = n_phase;
            r_next.ptog    = n_ptog;
            if (!sending) begin
                r_next.damp = 1'b0;
            end else begin
                unique case (mod_sel) // [R10]
                    MOD_ASK: r_next.damp = n_enc;
                    MOD_FSK: r_next.damp = fsk_out;
                    default: r_next.damp = n_ptog ^ n_phase;
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // Mode sequencing.
        unique case (r_reg.state)
            ST_POR: begin
                r_next.damp     = 1'b0;
                r_next.cyc_cnt  = 8'h00;
                r_next.bit_idx  = 7'h00;
                r_next.grp_cnt  = 4'h0;
                r_next.seen_gap = 1'b0;
                if (r_reg.pwr_lvl) begin // [R02]
                    r_next.state = locked ? ST_READ : ST_NATIVE;
                end
            end
            ST_NATIVE: begin
                if (!r_reg.fld_lvl) begin
                    r_next.seen_gap = 1'b1;
                end else if (r_reg.seen_gap) begin
                    r_next.state   = ST_BLANK; // [R20]
                    r_next.cyc_cnt = 8'h00;
                    r_next.bit_idx = 7'h00;
                    r_next.grp_cnt = 4'h0;
                end
            end
            ST_BLANK: begin
                if (car_rise && bit_end && r_reg.bit_idx == LAST_BIT_128) begin
                    r_next.state = ST_PROG; // [R21]
                end
            end
            ST_PROG: begin
                // Sample mid-bit, well away from the programmer's edges.
                if (car_rise && n_cyc == {1'b0, period[7:1]} && !locked) begin // [R05]
                    r_next.mem[r_reg.bit_idx] = r_reg.dat_lvl; // [R16]
                end
                if (car_rise && bit_end && r_reg.bit_idx == LAST_BIT_128) begin
                    r_next.state = ST_ECHO; // [R22]
                end
            end
            ST_ECHO: begin
                if (car_rise && bit_end && r_reg.bit_idx == LAST_BIT_128) begin
                    r_next.state = ST_PROG; // [R22]
                end
            end
            ST_READ: begin
            end
        endcase
        if ((r_reg.state == ST_PROG || r_reg.state == ST_ECHO) && !r_reg.fld_lvl) begin
            r_next.cfg[POS_LOCK] = 1'b1; // [R04] [R22]
            r_next.state = ST_POR;
        end
        if (!r_reg.pwr_lvl) begin
            r_next.state = ST_POR; // [R02]
        end

        ////////////////////////////////////////////////////////////////////////////
        // AXI4-Lite slave.
        cfg_view = r_reg.cfg;
        cfg_view[POS_RESERVED] = 1'b0; // [R04]
        if (s_axi_awvalid && !r_reg.aw_got && !r_reg.bvalid) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_reg.w_got && !r_reg.bvalid) begin
            r_next.w_got = 1'b1;
            r_next.wdata = s_axi_wdata;
            r_next.wstrb = s_axi_wstrb;
        end
        if (r_reg.aw_got && r_reg.w_got) begin
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = RESP_OKAY;
            if (r_reg.awaddr == OFS_CONFIG_LOAD) begin
                // Only the protocol bits load, and only into an unlocked part.
                if (!locked && r_reg.wstrb[0] && r_reg.wstrb[1]) begin // [R05]
                    r_next.cfg[9:0] = r_reg.wdata[9:0]; // [R17]
                end
            end else if (r_reg.awaddr != OFS_CONFIG && r_reg.awaddr != OFS_STATUS &&
                         !(r_reg.awaddr >= OFS_ARRAY_0 && r_reg.awaddr <= OFS_ARRAY_3 &&
                           r_reg.awaddr[1:0] == 2'h0)) begin
                r_next.bresp = RESP_SLVERR;
            end
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r_reg.rvalid) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = RESP_OKAY;
            r_next.rdata  = 32'h0000_0000;
            if (s_axi_araddr == OFS_CONFIG) begin
                r_next.rdata = {20'h00000, cfg_view}; // [R17]
            end else if (s_axi_araddr == OFS_CONFIG_LOAD) begin
                r_next.rdata = {22'h000000, r_reg.cfg[9:0]};
            end else if (s_axi_araddr == OFS_STATUS) begin
                r_next.rdata = {16'h0000, r_reg.damp, r_reg.bit_idx, 2'h0, r_reg.state};
            end else if (s_axi_araddr >= OFS_ARRAY_0 && s_axi_araddr <= OFS_ARRAY_3 &&
                         s_axi_araddr[1:0] == 2'h0) begin
                r_next.rdata = r_reg.mem[{s_axi_araddr[3:2], 5'h00} +: 32];
            end else begin
                r_next.rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign damping_on    = r_reg.damp; // [R03]
    assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
    assign s_axi_wready  = !r_reg.w_got && !r_reg.bvalid;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = !r_reg.rvalid;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rdata   = r_reg.rdata;
    assign s_axi_rresp   = r_reg.rresp;

endmodule

`default_nettype wire

/* File: include/ptem_pkg.sv */
// Package with constants, state codes and state record of the tag encoder and modulator.
package ptem_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFS_CONFIG      = 8'h00;
    localparam logic [7:0] OFS_CONFIG_LOAD = 8'h04;
    localparam logic [7:0] OFS_STATUS      = 8'h08;
    localparam logic [7:0] OFS_ARRAY_0     = 8'h10;
    localparam logic [7:0] OFS_ARRAY_3     = 8'h1C;

    // Configuration word field positions.
    localparam int POS_LEN      = 0;
    localparam int POS_RATE_LO  = 1;
    localparam int POS_ENC_LO   = 5;
    localparam int POS_MOD_LO   = 7;
    localparam int POS_RESERVED = 10;
    localparam int POS_LOCK     = 11;

    // Rate field codes, high bit first, and their carrier cycles per bit.
    localparam logic [2:0] RATE_CODE_32 = 3'h6;
    localparam logic [2:0] RATE_CODE_40 = 3'h4;
    localparam logic [2:0] RATE_CODE_50 = 3'h5;
    localparam logic [7:0] DIVIDE_32_RATE          = 8'h20;
    localparam logic [7:0] DIVIDE_40_RATE          = 8'h28;
    localparam logic [7:0] DIVIDE_50_RATE          = 8'h32;
    localparam logic [7:0] DIVIDE_128_DEFAULT_RATE = 8'h80;

    // Encoding and modulation field codes.
    localparam logic [1:0] ENC_NRZ_LEVEL   = 2'h0;
    localparam logic [1:0] ENC_MANCHESTER  = 2'h1;
    localparam logic [1:0] ENC_DIFF_BIPHASE = 2'h2;
    localparam logic [1:0] ENC_INV_MANCH   = 2'h3;
    localparam logic [1:0] MOD_FSK                   = 2'h0;
    localparam logic [1:0] MOD_PHASE_FLIP_ON_DATA_CHANGE = 2'h1;
    localparam logic [1:0] MOD_ASK                   = 2'h2;
    localparam logic [1:0] MOD_PHASE_FLIP_ON_ONE     = 2'h3;

    // FSK group lengths in carrier cycles.
    localparam logic [3:0] FSK_GROUP_HIGH = 4'hA;
    localparam logic [3:0] FSK_GROUP_LOW  = 4'h8;

    // Frame lengths, last bit index.
    localparam logic [6:0] LAST_BIT_96  = 7'h5F;
    localparam logic [6:0] LAST_BIT_128 = 7'h7F;

    // Values after reset, and the error response code.
    localparam logic [127:0] ARRAY_BLANK   = {128{1'b1}};
    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_SLVERR   = 2'h2;

    typedef enum logic [5:0] {
        ST_POR    = 6'h01,
        ST_NATIVE = 6'h02,
        ST_BLANK  = 6'h04,
        ST_PROG   = 6'h08,
        ST_ECHO   = 6'h10,
        ST_READ   = 6'h20
    } ptem_state_type;

    typedef struct packed {
        logic [2:0]     car_sync;
        logic           car_lvl;
        logic [2:0]     fld_sync;
        logic           fld_lvl;
        logic [2:0]     pwr_sync;
        logic           pwr_lvl;
        logic [2:0]     dat_sync;
        logic           dat_lvl;
        ptem_state_type state;
        logic           seen_gap;
        logic [11:0]    cfg;
        logic [127:0]   mem;
        logic [6:0]     bit_idx;
        logic [7:0]     cyc_cnt;
        logic [3:0]     grp_cnt;
        logic           dlev;
        logic           enc;
        logic           phase;
        logic           ptog;
        logic           damp;
        logic           aw_got;
        logic [7:0]     awaddr;
        logic           w_got;
        logic [31:0]    wdata;
        logic [3:0]     wstrb;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } ptem_regs_type;

endpackage

/* File: tb/ptem_checker.sv */
// Checker of the tag encoder and modulator ports.
`timescale 1ns/1ps
`default_nettype none
module ptem_checker
    import ptem_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        carrier_clock,
    input wire logic        field_present,
    input wire logic        supply_good,
    input wire logic        damping_on,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    logic       car_reg;
    logic [7:0] since_reg;
    logic [7:0] ar_reg;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the raw carrier rose.
    always_ff @(posedge aclk) begin
        car_reg <= carrier_clock;
        if (!aresetn || (carrier_clock && !car_reg)) begin
            since_reg <= 8'h00;
        end else if (since_reg != 8'hFF) begin
            since_reg <= since_reg + 8'h01;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            ar_reg <= s_axi_araddr;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_por_damp: assert property (
        !supply_good [*8] |-> !damping_on) else $error("damping in reset");
    chk_damp_tick: assert property (
        $changed(damping_on) && supply_good && field_present |-> since_reg < 8'h08)
        else $error("damping off carrier edge");
    chk_write_ans: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("late write response");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    chk_aw_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    chk_read_ans: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("rvalid dropped");
    chk_ar_block: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_cfg_bits: assert property (
        s_axi_rvalid && ar_reg == OFS_CONFIG |-> !s_axi_rdata[10] && s_axi_rdata[31:12] == 20'h00000)
        else $error("config spare bits set");
    chk_unmapped: assert property (
        s_axi_rvalid && !(ar_reg inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C})
        |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000) else $error("unmapped read not refused");
endmodule
bind ptem_top ptem_checker i_ptem_checker (.*);
`default_nettype wire

/* File: tb/ptem_reader.sv */
// Behavioural reader and programmer that powers the tag and makes its carrier.
`timescale 1ns/1ps
`default_nettype none
module ptem_reader (
    input  wire logic aclk,
    output logic      carrier_clock,
    output logic      field_present,
    output logic      supply_good,
    output logic      program_data
);
    int ticks = 0;
    initial begin
        carrier_clock = 1'b0;
        field_present = 1'b0;
        supply_good   = 1'b0;
        program_data  = 1'b0;
        #37;
        forever begin
            #80;
            // The carrier stops while the field is off.
            carrier_clock = field_present ? ~carrier_clock : 1'b0;
        end
    end
    // Data toggles each carrier cycle.
    always @(posedge carrier_clock) begin
        ticks = ticks + 1;
        program_data = ~program_data;
    end
    task automatic set_power(input logic f, input logic s);
        @(posedge aclk);
        field_present <= f;
        supply_good <= s;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_ptem_top.sv */
// Self-checking testbench of the tag encoder and modulator.
`timescale 1ns/1ps
`default_nettype none
module test_ptem_top;
    import ptem_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire logic   carrier_clock, field_present, supply_good, program_data, damping_on;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int          err_total = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    always #5 aclk = ~aclk;
    ptem_reader i_ptem_reader (.*);
    ptem_top #(.FACTORY_CONFIG(12'hC0A)) i_ptem_top (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        err_total++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) fail($sformatf("word %h expected %h", g, e));
    endtask
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        cmp_count++;
        if (g !== e) fail($sformatf("response %h expected %h", g, e));
    endtask
    task automatic cmp_num(input int g, input int e);
        cmp_count++;
        if (g != e) fail($sformatf("count %0d expected %0d", g, e));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Late delays bready or rready.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input int late);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid || s_axi_wvalid) && n < 200);
        repeat (late) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 400);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 400) begin
            fail("write timeout");
            complete_run();
        end
    endtask
    task automatic axi_read(input logic [7:0] a, input int late);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 200);
        s_axi_arvalid <= 1'b0;
        repeat (late) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 400);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 400) begin
            fail("read timeout");
            complete_run();
        end
    endtask
    // Runs in carrier ticks: 5 undamped, 5 damped, a damped 3 closing each 128-tick bit.
    task automatic check_fsk(input int nbits);
        int t0, last_short, shorts, n;
        logic d;
        d = damping_on;
        t0 = -1;
        last_short = -1;
        shorts = 0;
        for (n = 0; n < nbits * 2048; n++) begin
            @(posedge aclk);
            if (damping_on !== d) begin
                if (t0 >= 0 && d === 1'b1 && i_ptem_reader.ticks - t0 == 3) begin
                    shorts++;
                    if (last_short >= 0) cmp_num(i_ptem_reader.ticks - last_short, 128);
                    last_short = i_ptem_reader.ticks;
                end else if (t0 >= 0) begin
                    cmp_num(i_ptem_reader.ticks - t0, 5);
                end
                t0 = i_ptem_reader.ticks;
                d = damping_on;
            end
        end
        cmp_num(int'(shorts >= nbits - 1), 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (12) @(posedge aclk);
        axi_read(OFS_STATUS, 0);
        cmp_word(rd & 32'h0000803F, 32'h00000001);
        axi_read(OFS_CONFIG, 3);
        cmp_word(rd, 32'h0000000A);
        axi_write(OFS_CONFIG_LOAD, 32'hFFFFFFFF, 4'hF, 0);
        cmp_resp(rs, RESP_OKAY);
        axi_read(OFS_CONFIG, 0);
        cmp_word(rd, 32'h000003FF);
        axi_write(OFS_CONFIG_LOAD, 32'h00000000, 4'h1, 2);
        axi_write(OFS_CONFIG, 32'h00000000, 4'hF, 0);
        cmp_resp(rs, RESP_OKAY);
        axi_read(OFS_CONFIG, 0);
        cmp_word(rd, 32'h000003FF);
        axi_write(8'h40, 32'h00000001, 4'hF, 0);
        cmp_resp(rs, RESP_SLVERR);
        axi_read(8'h44, 0);
        cmp_resp(rs, RESP_SLVERR);
        cmp_word(rd, 32'h00000000);
        for (int k = 0; k < 4; k++) begin
            axi_read(OFS_ARRAY_0 + 8'(4 * k), 0);
            cmp_word(rd, 32'hFFFFFFFF);
        end
        // ASK, rate 32 and Manchester are chosen but must not act while unlocked.
        axi_write(OFS_CONFIG_LOAD, 32'h0000012C, 4'hF, 0);
        i_ptem_reader.set_power(1'b1, 1'b1);
        repeat (200) @(posedge aclk);
        axi_read(OFS_STATUS, 0);
        cmp_word(rd & 32'h0000003F, 32'h00000002);
        check_fsk(3);
        i_ptem_reader.set_power(1'b0, 1'b1);
        repeat (320) @(posedge aclk);
        i_ptem_reader.set_power(1'b1, 1'b1);
        repeat (100) @(posedge aclk);
        axi_read(OFS_STATUS, 0);
        cmp_word(rd & 32'h0000003F, 32'h00000004);
        check_fsk(3);
        i_ptem_reader.set_power(1'b1, 1'b0);
        repeat (20) @(posedge aclk);
        cmp_word({31'h0, damping_on}, 32'h00000000);
        axi_read(OFS_STATUS, 0);
        cmp_word(rd & 32'h0000803F, 32'h00000001);
        complete_run();
    end
endmodule
`default_nettype wire
